// [rtl/fpr_params.svh]
// Constants shared by both ends of the power, reset and terminate command link.
`ifndef FPR_PARAMS_SVH
`define FPR_PARAMS_SVH
`define FPR_CLK_NS        4
`define FPR_OP_ULTRA_LOW_POWER_STATE       8'h79
`define FPR_OP_DPD        8'hB9
`define FPR_OP_RESUME     8'hAB
`define FPR_OP_RST_EN     8'h66
`define FPR_OP_RST        8'h99
`define FPR_OP_TERM       8'hF0
`define FPR_TERM_CONF     8'hD0
`define FPR_ULTRA_LOW_POWER_ENTRY_LATENCY_NS    3000
`define FPR_SOFTWARE_RESET_LATENCY_NS    10000
`define FPR_TERMINATE_LATENCY_NS   10000
`define FPR_T_WAKE_NS     8000
`define FPR_EUDPD_CYC     ((`FPR_ULTRA_LOW_POWER_ENTRY_LATENCY_NS / `FPR_CLK_NS) > 0 ? (`FPR_ULTRA_LOW_POWER_ENTRY_LATENCY_NS / `FPR_CLK_NS) : 1)
`define FPR_SWRST_CYC     ((`FPR_SOFTWARE_RESET_LATENCY_NS / `FPR_CLK_NS) > 0 ? (`FPR_SOFTWARE_RESET_LATENCY_NS / `FPR_CLK_NS) : 1)
`define FPR_SWTERM_CYC    ((`FPR_TERMINATE_LATENCY_NS / `FPR_CLK_NS) > 0 ? (`FPR_TERMINATE_LATENCY_NS / `FPR_CLK_NS) : 1)
`define FPR_WAKE_CYC      ((`FPR_T_WAKE_NS / `FPR_CLK_NS) > 0 ? (`FPR_T_WAKE_NS / `FPR_CLK_NS) : 1)
`define FPR_CNT_W         12
`define FPR_SYNC_RST      3'h4
`define FPR_SCLK_HALF     4'hA
`define FPR_ADDR_CMD      4'h0
`define FPR_ADDR_STAT     4'h4
`define FPR_CMD_B0_LSB    0
`define FPR_CMD_B1_LSB    8
`define FPR_CMD_NBY_LSB   16
`define FPR_CMD_XB_LSB    18
`endif

// [rtl/fpr_pkg.sv]
// Types shared by both ends of the power, reset and terminate command link.
package fpr_pkg;
  typedef enum logic [2:0] {
    FPR_MD_STBY, FPR_MD_DPD, FPR_MD_ULTRA_LOW_POWER_STATE, FPR_MD_GO_DPD, FPR_MD_GO_ULTRA_LOW_POWER_STATE,
    FPR_MD_WAKE, FPR_MD_RST, FPR_MD_TERM
  } fpr_mode_e;
  typedef enum logic [1:0] {FPR_H_IDLE, FPR_H_RUN, FPR_H_GAP} fpr_hst_e;
endpackage

// [rtl/fpr_if.sv]
// Serial link between the host controller and the flash command end.
`timescale 1ns/1ns
`default_nettype none
interface fpr_if;
  logic cs_n;
  logic sclk;
  logic si;
  modport dev  (input cs_n, input sclk, input si);
  modport host (output cs_n, output sclk, output si);
endinterface // fpr_if
`default_nettype wire

// [rtl/fpr_dev.sv]
// Flash end: decodes power-down, resume, software reset and terminate commands.
`timescale 1ns/1ns
`default_nettype none
`include "fpr_params.svh"
module fpr_dev
  import fpr_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Serial link
  fpr_if.dev        link,
  // Status from the rest of the flash
  input  wire logic busy_flag,
  input  wire logic power_down_select_bit,
  input  wire logic terminate_enable_bit,
  // State and actions toward the rest of the flash
  output logic      standby,
  output logic      ultra_low_power_state,
  output logic      lighter_power_down_state,
  output logic      cmd_locked,
  output logic      soft_reset,
  output logic      abort_op
);
  // Pins come from the host's domain; two flops before any logic, order {cs_n, sclk, si}.
  logic [2:0]      s1_r;
  logic [2:0]      s2_r;

  fpr_mode_e       mode_r, mode_nxt;
  logic [7:0]      sh_r, sh_nxt;
  logic [7:0]      op_r, op_nxt;
  logic [7:0]      cf_r, cf_nxt;
  logic [2:0]      bits_r, bits_nxt;
  logic [1:0]      nby_r, nby_nxt;
  logic            arm_r, arm_nxt;
  logic [`FPR_CNT_W-1:0] cnt_r, cnt_nxt;
  logic            sclk_d_r, sclk_d_nxt;
  logic            cs_d_r, cs_d_nxt;
  logic            soft_reset_nxt;
  logic            abort_op_nxt;
  logic            cs_n_s;
  logic            sclk_s;
  logic            si_s;
  logic            cs_rise;
  logic            whole;

  assign cs_n_s = s2_r[2];
  assign sclk_s = s2_r[1];
  assign si_s   = s2_r[0];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= `FPR_SYNC_RST;
      s2_r <= `FPR_SYNC_RST;
    end
    else
    begin
      s1_r <= {link.cs_n, link.sclk, link.si};
      s2_r <= s1_r;
    end
  end

  always_comb
  begin
    mode_nxt       = mode_r;
    sh_nxt         = sh_r;
    op_nxt         = op_r;
    cf_nxt         = cf_r;
    bits_nxt       = bits_r;
    nby_nxt        = nby_r;
    arm_nxt        = arm_r;
    cnt_nxt        = cnt_r;
    sclk_d_nxt     = sclk_s;
    cs_d_nxt       = cs_n_s;
    soft_reset_nxt = 1'b0;
    abort_op_nxt   = 1'b0;
    cs_rise        = cs_n_s && !cs_d_r;
    // A command counts only when it ends on a byte boundary with at least one byte.
    whole          = (bits_r == 3'h0) && (nby_r != 2'h0);

    // Shift in on each serial clock rise while selected, MSB first.
    if (!cs_n_s && sclk_s && !sclk_d_r)
    begin
      sh_nxt   = {sh_r[6:0], si_s};
      bits_nxt = bits_r + 3'h1;
      if (bits_r == 3'h7)
      begin
        if (nby_r == 2'h0)
          op_nxt = sh_nxt;
        else if (nby_r == 2'h1)
          cf_nxt = sh_nxt;
        // Later bytes are neither counted nor decoded; the byte count holds at two.
        if (nby_r != 2'h2)
          nby_nxt = nby_r + 2'h1;
      end
    end
    else if (cs_n_s)
    begin
      bits_nxt = 3'h0;
      nby_nxt  = 2'h0;
    end

    // Timed states count down and then settle.
    if (cnt_r != '0)
      cnt_nxt = cnt_r - `FPR_CNT_W'(1);
    else
    begin
      case (mode_r)
        FPR_MD_GO_ULTRA_LOW_POWER_STATE: mode_nxt = FPR_MD_ULTRA_LOW_POWER_STATE;
        FPR_MD_GO_DPD:  mode_nxt = FPR_MD_DPD;
        FPR_MD_WAKE,
        FPR_MD_RST,
        FPR_MD_TERM:    mode_nxt = FPR_MD_STBY;
        default:        mode_nxt = mode_r;
      endcase
    end

    // Decoding happens only on deselect; the timed states refuse everything.
    if (cs_rise && whole)
    begin
      if (op_r != `FPR_OP_RST)
        arm_nxt = (op_r == `FPR_OP_RST_EN) && (mode_r == FPR_MD_STBY || mode_r == FPR_MD_DPD);
      case (mode_r)
        FPR_MD_STBY:
        begin
          if (op_r == `FPR_OP_ULTRA_LOW_POWER_STATE && !busy_flag)
          begin
            mode_nxt = FPR_MD_GO_ULTRA_LOW_POWER_STATE;
            cnt_nxt  = `FPR_CNT_W'(`FPR_EUDPD_CYC);
          end
          else if (op_r == `FPR_OP_DPD && !busy_flag)
          begin
            mode_nxt = power_down_select_bit ? FPR_MD_GO_DPD : FPR_MD_GO_ULTRA_LOW_POWER_STATE;
            cnt_nxt  = `FPR_CNT_W'(`FPR_EUDPD_CYC);
          end
          // The write enable latch is deliberately not consulted here.
          else if (op_r == `FPR_OP_TERM && nby_r == 2'h2 && cf_r == `FPR_TERM_CONF
                   && terminate_enable_bit)
          begin
            // Only the engine is aborted; configuration survives, page data may not.
            mode_nxt     = FPR_MD_TERM;
            cnt_nxt      = `FPR_CNT_W'(`FPR_SWTERM_CYC);
            abort_op_nxt = 1'b1;
          end
          else if (op_r == `FPR_OP_RST && arm_r)
          begin
            mode_nxt       = FPR_MD_RST;
            cnt_nxt        = `FPR_CNT_W'(`FPR_SWRST_CYC);
            soft_reset_nxt = 1'b1;
            abort_op_nxt   = 1'b1;
            arm_nxt        = 1'b0;
          end
          else if (op_r == `FPR_OP_RST)
            arm_nxt = 1'b0;
        end
        FPR_MD_DPD:
        begin
          if (op_r == `FPR_OP_RESUME)
          begin
            mode_nxt = FPR_MD_WAKE;
            cnt_nxt  = `FPR_CNT_W'(`FPR_WAKE_CYC);
          end
          else if (op_r == `FPR_OP_RST && arm_r)
          begin
            mode_nxt       = FPR_MD_RST;
            cnt_nxt        = `FPR_CNT_W'(`FPR_SWRST_CYC);
            soft_reset_nxt = 1'b1;
            abort_op_nxt   = 1'b1;
            arm_nxt        = 1'b0;
          end
          else if (op_r == `FPR_OP_RST)
            arm_nxt = 1'b0;
        end
        FPR_MD_ULTRA_LOW_POWER_STATE:
        begin
          arm_nxt = 1'b0;
          if (op_r == `FPR_OP_RESUME)
          begin
            mode_nxt = FPR_MD_WAKE;
            cnt_nxt  = `FPR_CNT_W'(`FPR_WAKE_CYC);
          end
        end
        default:
          arm_nxt = arm_r;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r                   <= FPR_MD_STBY;
      sh_r                     <= 8'h00;
      op_r                     <= 8'h00;
      cf_r                     <= 8'h00;
      bits_r                   <= 3'h0;
      nby_r                    <= 2'h0;
      arm_r                    <= 1'b0;
      cnt_r                    <= '0;
      sclk_d_r                 <= 1'b0;
      cs_d_r                   <= 1'b1;
      standby                  <= 1'b1;
      ultra_low_power_state    <= 1'b0;
      lighter_power_down_state <= 1'b0;
      cmd_locked               <= 1'b0;
      soft_reset               <= 1'b0;
      abort_op                 <= 1'b0;
    end
    else
    begin
      mode_r                   <= mode_nxt;
      sh_r                     <= sh_nxt;
      op_r                     <= op_nxt;
      cf_r                     <= cf_nxt;
      bits_r                   <= bits_nxt;
      nby_r                    <= nby_nxt;
      arm_r                    <= arm_nxt;
      cnt_r                    <= cnt_nxt;
      sclk_d_r                 <= sclk_d_nxt;
      cs_d_r                   <= cs_d_nxt;
      standby                  <= (mode_nxt == FPR_MD_STBY);
      ultra_low_power_state    <= (mode_nxt == FPR_MD_ULTRA_LOW_POWER_STATE);
      lighter_power_down_state <= (mode_nxt == FPR_MD_DPD);
      cmd_locked               <= (mode_nxt == FPR_MD_RST) || (mode_nxt == FPR_MD_TERM);
      soft_reset               <= soft_reset_nxt;
      abort_op                 <= abort_op_nxt;
    end
  end
endmodule // fpr_dev
`default_nettype wire

// [rtl/fpr_host.sv]
// Host end: Avalon-MM command registers driving the serial command link.
`timescale 1ns/1ns
`default_nettype none
`include "fpr_params.svh"
module fpr_host
  import fpr_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Serial link
  fpr_if.host              link
);
  fpr_hst_e    st_r, st_nxt;
  logic [31:0] cmd_r, cmd_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [4:0]  left_r, left_nxt;
  logic [3:0]  div_r, div_nxt;
  logic        cs_n_r, cs_n_nxt;
  logic        sclk_r, sclk_nxt;
  logic        si_r, si_nxt;
  logic [31:0] rdata_nxt;
  logic        wait_nxt;
  logic        take;
  logic [4:0]  total;

  assign link.cs_n = cs_n_r;
  assign link.sclk = sclk_r;
  assign link.si   = si_r;

  always_comb
  begin
    st_nxt    = st_r;
    cmd_nxt   = cmd_r;
    sh_nxt    = sh_r;
    left_nxt  = left_r;
    div_nxt   = div_r;
    cs_n_nxt  = cs_n_r;
    sclk_nxt  = sclk_r;
    si_nxt    = si_r;
    rdata_nxt = readdata;
    // Every access sees exactly one wait cycle, then is taken.
    wait_nxt  = !((read || write) && waitrequest);
    take      = (read || write) && !waitrequest;
    total     = 5'({writedata[`FPR_CMD_NBY_LSB +: 2], 3'h0})
              + 5'(writedata[`FPR_CMD_XB_LSB +: 3]);

    if ((read || write) && waitrequest)
    begin
      if (address == `FPR_ADDR_CMD)
        rdata_nxt = cmd_r;
      else if (address == `FPR_ADDR_STAT)
        rdata_nxt = {31'h0, st_r != FPR_H_IDLE};
      else
        rdata_nxt = 32'h0;
    end

    if (div_r != 4'h0)
      div_nxt = div_r - 4'h1;

    case (st_r)
      FPR_H_IDLE:
      begin
        // A new command is refused while one is still on the link.
        if (take && write && address == `FPR_ADDR_CMD)
        begin
          cmd_nxt  = writedata;
          sh_nxt   = {writedata[`FPR_CMD_B0_LSB +: 8], writedata[`FPR_CMD_B1_LSB +: 8]};
          left_nxt = total;
          si_nxt   = writedata[`FPR_CMD_B0_LSB + 7];
          div_nxt  = `FPR_SCLK_HALF;
          st_nxt   = (total == 5'h0) ? FPR_H_GAP : FPR_H_RUN;
          cs_n_nxt = (total == 5'h0);
        end
      end
      FPR_H_RUN:
      begin
        if (div_r == 4'h0)
        begin
          div_nxt  = `FPR_SCLK_HALF;
          sclk_nxt = !sclk_r;
          if (sclk_r)
          begin
            sh_nxt   = {sh_r[14:0], 1'b0};
            si_nxt   = sh_r[14];
            left_nxt = left_r - 5'h1;
            if (left_r == 5'h1)
            begin
              // Deselect is held two half periods, a full serial clock, so that
              // back-to-back 66h/99h frames keep their gap.
              cs_n_nxt = 1'b1;
              st_nxt   = FPR_H_GAP;
              left_nxt = 5'h1;
            end
          end
        end
      end
      FPR_H_GAP:
      begin
        si_nxt = 1'b0;
        if (div_r == 4'h0)
        begin
          if (left_r == 5'h0)
            st_nxt = FPR_H_IDLE;
          else
          begin
            left_nxt = 5'h0;
            div_nxt  = `FPR_SCLK_HALF;
          end
        end
      end
      default:
        st_nxt = FPR_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r        <= FPR_H_IDLE;
      cmd_r       <= 32'h0;
      sh_r        <= 16'h0;
      left_r      <= 5'h0;
      div_r       <= 4'h0;
      cs_n_r      <= 1'b1;
      sclk_r      <= 1'b0;
      si_r        <= 1'b0;
      readdata    <= 32'h0;
      waitrequest <= 1'b1;
    end
    else
    begin
      st_r        <= st_nxt;
      cmd_r       <= cmd_nxt;
      sh_r        <= sh_nxt;
      left_r      <= left_nxt;
      div_r       <= div_nxt;
      cs_n_r      <= cs_n_nxt;
      sclk_r      <= sclk_nxt;
      si_r        <= si_nxt;
      readdata    <= rdata_nxt;
      waitrequest <= wait_nxt;
    end
  end
endmodule // fpr_host
`default_nettype wire

// [dv/fpr_link_checker.sv]
// Assertions on the command link and the flash end's state outputs.
`timescale 1ns/1ns
`default_nettype none
module fpr_link_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Link and flash end state
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic standby,
  input wire logic ultra_low_power_state,
  input wire logic lighter_power_down_state,
  input wire logic cmd_locked,
  input wire logic soft_reset,
  input wire logic abort_op
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves while deselected");
  property p_ulp_alone;
    ultra_low_power_state |-> !standby && !lighter_power_down_state;
  endproperty
  a_ulp_alone: assert property (p_ulp_alone) else $error("deep state not exclusive");
  property p_ulp_deaf;
    ultra_low_power_state |-> !soft_reset && !abort_op;
  endproperty
  a_ulp_deaf: assert property (p_ulp_deaf) else $error("action in deep state");
  property p_rst_pulse;
    soft_reset |=> !soft_reset;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_rst_abort;
    soft_reset |-> abort_op;
  endproperty
  a_rst_abort: assert property (p_rst_abort) else $error("reset without abort");
  property p_act_idle;
    abort_op |-> cs_n && $past(cs_n, 2);
  endproperty
  a_act_idle: assert property (p_act_idle) else $error("action before deselect");
  property p_lock_after;
    abort_op |-> ##[0:2] cmd_locked;
  endproperty
  a_lock_after: assert property (p_lock_after) else $error("no lock after action");
  property p_lock_hold;
    $rose(cmd_locked) |=> cmd_locked [*8];
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock dropped early");
  property p_wake_first;
    $fell(ultra_low_power_state) |-> !standby;
  endproperty
  a_wake_first: assert property (p_wake_first) else $error("standby without wake");
endmodule // fpr_link_checker
`default_nettype wire

// [dv/tb_top.sv]
// Testbench joining the host and flash ends over the command link.
`timescale 1ns/1ns
`default_nettype none
`include "fpr_params.svh"
module tb_top;
  logic        mclk;
  logic        rst_n;
  logic [3:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        busy_flag;
  logic        power_down_select_bit;
  logic        terminate_enable_bit;
  logic        standby;
  logic        ultra_low_power_state;
  logic        lighter_power_down_state;
  logic        cmd_locked;
  logic        soft_reset;
  logic        abort_op;
  logic [31:0] rdata;
  logic [7:0]  wire_sr;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n_rst = 0;
  int          n_abt = 0;
  fpr_if link ();
  fpr_host u_fpr_host (.mclk, .rst_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .link);
  fpr_dev u_fpr_dev (.mclk, .rst_n, .link, .busy_flag, .power_down_select_bit,
    .terminate_enable_bit, .standby, .ultra_low_power_state, .lighter_power_down_state,
    .cmd_locked, .soft_reset, .abort_op);
  fpr_link_checker u_fpr_link_checker (.mclk, .rst_n, .cs_n(link.cs_n), .sclk(link.sclk),
    .standby, .ultra_low_power_state, .lighter_power_down_state, .cmd_locked,
    .soft_reset, .abort_op);
  initial
  begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  // The bench rebuilds each byte from the wire so bit order is judged independently.
  always @(posedge link.sclk)
    if (link.cs_n === 1'h0) wire_sr <= {wire_sr[6:0], link.si};
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (soft_reset === 1'h1) n_rst <= n_rst + 1;
    if (abort_op === 1'h1) n_abt <= n_abt + 1;
    if (cycles == 60000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    do @(posedge mclk); while (waitrequest !== 1'h0);
    rdata = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [1:0] nby,
                       input logic [2:0] xb);
    int n;
    av(1'h1, `FPR_ADDR_CMD, {11'h000, xb, nby, b1, b0});
    n = 0;
    do
    begin
      av(1'h0, `FPR_ADDR_STAT, 32'h0);
      n++;
    end
    while (rdata[0] !== 1'h0 && n < 1000);
    // A link that never goes idle counts as a mismatch here.
    check("link_idle", rdata[7:0], 8'h00);
    repeat (30) @(posedge mclk);
  endtask
  task automatic t_ulp();
    busy_flag <= 1'h1;
    frame(8'h79, 8'h00, 2'h1, 3'h0);
    check("wire_byte", wire_sr, 8'h79);
    repeat (`FPR_EUDPD_CYC + 50) @(posedge mclk);
    check("ulp_busy", ultra_low_power_state, 1'h0);
    busy_flag <= 1'h0;
    frame(8'h79, 8'h00, 2'h1, 3'h3);
    repeat (`FPR_EUDPD_CYC + 50) @(posedge mclk);
    check("ulp_cut", {ultra_low_power_state, standby}, 2'h1);
    frame(8'h79, 8'h55, 2'h2, 3'h0);
    repeat (`FPR_EUDPD_CYC + 50) @(posedge mclk);
    check("ulp_on", {ultra_low_power_state, standby}, 2'h2);
    frame(8'h66, 8'h00, 2'h1, 3'h0);
    frame(8'h99, 8'h00, 2'h1, 3'h0);
    check("ulp_deaf", n_rst[7:0], 8'h00);
    frame(8'hAB, 8'h00, 2'h1, 3'h2);
    repeat (`FPR_WAKE_CYC + 50) @(posedge mclk);
    check("ulp_abcut", ultra_low_power_state, 1'h1);
    frame(8'hAB, 8'h00, 2'h1, 3'h0);
    check("ulp_waking", {ultra_low_power_state, standby}, 2'h0);
    repeat (`FPR_WAKE_CYC + 50) @(posedge mclk);
    check("ulp_wake", {ultra_low_power_state, standby}, 2'h1);
  endtask
  task automatic t_light();
    frame(8'hB9, 8'h00, 2'h1, 3'h0);
    repeat (`FPR_EUDPD_CYC + 50) @(posedge mclk);
    check("b9_ulp", ultra_low_power_state, 1'h1);
    frame(8'hAB, 8'h00, 2'h1, 3'h0);
    repeat (`FPR_WAKE_CYC + 50) @(posedge mclk);
    power_down_select_bit <= 1'h1;
    terminate_enable_bit <= 1'h1;
    frame(8'hB9, 8'h00, 2'h1, 3'h0);
    repeat (`FPR_EUDPD_CYC + 50) @(posedge mclk);
    check("b9_light", {lighter_power_down_state, standby}, 2'h2);
    frame(8'hF0, 8'hD0, 2'h2, 3'h0);
    frame(8'h79, 8'h00, 2'h1, 3'h0);
    repeat (`FPR_EUDPD_CYC + 50) @(posedge mclk);
    check("light_deaf", {n_abt[5:0], lighter_power_down_state, ultra_low_power_state},
          8'h02);
    frame(8'h66, 8'h00, 2'h1, 3'h0);
    frame(8'h99, 8'h00, 2'h1, 3'h0);
    check("light_rst", n_rst[7:0], 8'h01);
    repeat (`FPR_SWRST_CYC + 50) @(posedge mclk);
    check("rst_dflt", {lighter_power_down_state, standby}, 2'h1);
  endtask
  task automatic t_rst();
    // Busy is low here, so the reset pair is only sent from a quiet device.
    frame(8'h66, 8'h00, 2'h1, 3'h0);
    frame(8'h99, 8'h00, 2'h1, 3'h0);
    check("wire_byte", wire_sr, 8'h99);
    check("rst_pulse", {n_rst[3:0], n_abt[3:0]}, 8'h22);
    check("rst_lock", cmd_locked, 1'h1);
    frame(8'h79, 8'h00, 2'h1, 3'h0);
    repeat (`FPR_SWRST_CYC + 50) @(posedge mclk);
    check("rst_refuse", {ultra_low_power_state, cmd_locked}, 2'h0);
    frame(8'h66, 8'h00, 2'h1, 3'h0);
    frame(8'hAB, 8'h00, 2'h1, 3'h0);
    frame(8'h99, 8'h00, 2'h1, 3'h0);
    check("rst_arm", n_rst[7:0], 8'h02);
    // The cut 66h still fills the opcode register, so only the boundary test can refuse it.
    frame(8'h66, 8'h00, 2'h1, 3'h3);
    frame(8'h99, 8'h00, 2'h1, 3'h0);
    check("rst_cut", n_rst[7:0], 8'h02);
  endtask
  task automatic t_term();
    terminate_enable_bit <= 1'h0;
    frame(8'hF0, 8'hD0, 2'h2, 3'h0);
    check("term_off", n_abt[7:0], 8'h02);
    terminate_enable_bit <= 1'h1;
    frame(8'hF0, 8'hD1, 2'h2, 3'h0);
    check("term_conf", n_abt[7:0], 8'h02);
    frame(8'hF0, 8'hD0, 2'h2, 3'h3);
    check("term_cut", n_abt[7:0], 8'h02);
    busy_flag <= 1'h1;
    frame(8'hF0, 8'hD0, 2'h2, 3'h0);
    check("term_go", {n_rst[3:0], n_abt[3:0]}, 8'h23);
    check("term_lock", cmd_locked, 1'h1);
    repeat (`FPR_SWTERM_CYC + 50) @(posedge mclk);
    check("term_idle", {cmd_locked, standby}, 2'h1);
    av(1'h0, `FPR_ADDR_CMD, 32'h0);
    check("cmd_back_b0", rdata[7:0], 8'hF0);
    check("cmd_back_b1", rdata[15:8], 8'hD0);
    check("cmd_back_len", rdata[23:16], 8'h02);
  endtask
  initial
  begin
    rst_n = 1'h0;
    read = 1'h0;
    write = 1'h0;
    address = 4'h0;
    writedata = 32'h0;
    busy_flag = 1'h0;
    power_down_select_bit = 1'h0;
    terminate_enable_bit = 1'h0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (4) @(posedge mclk);
    av(1'h0, 4'h8, 32'h0);
    check("unmapped", rdata[7:0], 8'h00);
    t_ulp();
    t_light();
    t_rst();
    t_term();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
